// ### core/adc_count_and_control_sequencer.sv
// Count-and-control sequencer for a converter built from an external integrator, comparator and DAC.
`timescale 1ns/1ps
module adc_count_and_control_sequencer #(
  parameter int unsigned DATA_W       = adc_seq_pkg::DATA_W_DEF,
  parameter int unsigned INTEG_CYCLES = adc_seq_pkg::INTEG_CYCLES_DEF,
  parameter int unsigned STEP_DIV     = adc_seq_pkg::STEP_DIV_DEF
) (
  // Clock and reset.
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_n_i,
  // Control from host logic on the same clock.
  input  wire adc_seq_pkg::conv_mode_t mode_i,
  input  wire logic                    start_i,
  // Comparator pin from the analog front end.
  input  wire logic                    comp_i,
  // Analog front end drive.
  output adc_seq_pkg::integ_sel_t      integ_sel_o,
  output logic [DATA_W-1:0]            dac_code_o,
  // Conversion result.
  output logic [DATA_W-1:0]            result_o,
  output logic                         done_o,
  output logic                         busy_o
);
  import adc_seq_pkg::*;

  // All checks below run on the system clock and rest while reset is low.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Counter widths and handy code values.
  localparam int unsigned        IW        = $clog2(INTEG_CYCLES + 1);
  localparam int unsigned        TW        = (STEP_DIV > 1) ? $clog2(STEP_DIV) : 1;
  localparam logic [IW-1:0]      INTEG_LAST = IW'(INTEG_CYCLES - 1);
  localparam logic [TW-1:0]      TICK_LAST  = TW'(STEP_DIV - 1);
  localparam logic [DATA_W-1:0]  CODE_MAX   = '1;
  localparam logic [DATA_W-1:0]  CODE_MSB   = {1'h1, {(DATA_W-1){1'h0}}};

  seq_state_t        state;      // Current sequencer state.
  logic              comp_meta;  // First synchroniser stage.
  logic              comp_s;     // Synchronised comparator level.
  logic [TW-1:0]     tick_cnt;   // Step divider.
  logic              tick;       // One-cycle step enable.
  logic [IW-1:0]     integ_cnt;  // Cycles spent integrating.
  logic [DATA_W-1:0] run_cnt;    // Count during the rundown count period.
  logic [DATA_W-1:0] sar_mask;   // One-hot bit under trial.
  logic [DATA_W-1:0] next_sar_code;
  logic              start_ok;   // Start taken only when idle.
  logic              integ_end;
  logic              rundown_end;
  logic              stair_end;
  logic              sar_end;
  logic              track_end;

  // Comparator meaning: in direct modes high says the DAC is at or below the input;
  // in dual-slope, high says the integrator has not yet reached the rundown_stop_threshold.

  // Requests during a conversion are ignored rather than queued.
  assign start_ok    = start_i && (state == ST_IDLE);
  assign tick        = (tick_cnt == TICK_LAST);
  assign integ_end   = (state == ST_INTEG) && (integ_cnt == INTEG_LAST);
  assign rundown_end = (state == ST_RUNDOWN) && (!comp_s || run_cnt == CODE_MAX);
  assign stair_end   = (state == ST_STAIR) && tick && (!comp_s || dac_code_o == CODE_MAX);
  assign sar_end     = (state == ST_SAR) && tick && sar_mask[0];
  assign track_end   = (state == ST_TRACK) && (mode_i != MODE_TRACK);

  // Settle the trial bit and raise the next one.
  assign next_sar_code = (comp_s ? dac_code_o : (dac_code_o & ~sar_mask)) | (sar_mask >> 1);

  // Two-stage synchroniser; only comp_s is read by logic.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      comp_meta <= 1'h0;
      comp_s    <= 1'h0;
    end else begin
      comp_meta <= comp_i;
      comp_s    <= comp_meta;
    end
  end

  // Step divider, restarted on start so every conversion has the same step phase.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt <= '0;
    end else if (start_ok || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'h1;
    end
  end

  // Sequencer state.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start_i) begin
            unique case (mode_i)
              MODE_DUAL:  state <= ST_INTEG;
              MODE_STAIR: state <= ST_STAIR;
              MODE_TRACK: state <= ST_TRACK;
              MODE_SAR:   state <= ST_SAR;
            endcase
          end
        end
        ST_INTEG: begin
          if (integ_end) begin
            state <= ST_RUNDOWN;
          end
        end
        ST_RUNDOWN: begin
          if (rundown_end) begin
            state <= ST_IDLE;
          end
        end
        ST_STAIR: begin
          if (stair_end) begin
            state <= ST_IDLE;
          end
        end
        ST_SAR: begin
          if (sar_end) begin
            state <= ST_IDLE;
          end
        end
        ST_TRACK: begin
          if (track_end) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Integrator switch: input for the fixed period, then the reference until the threshold.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      integ_sel_o <= INTEG_SEL_RESET;
    end else if (start_ok && mode_i == MODE_DUAL) begin
      integ_sel_o <= 2'h2;
    end else if (integ_end) begin
      integ_sel_o <= 2'h1;
    end else if (rundown_end || state == ST_IDLE) begin
      integ_sel_o <= INTEG_SEL_RESET;
    end
  end

  // Integration period counter.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      integ_cnt <= '0;
    end else if (start_ok) begin
      integ_cnt <= '0;
    end else if (state == ST_INTEG) begin
      integ_cnt <= integ_cnt + 1'h1;
    end
  end

  // Rundown counter; saturates so a missing threshold cannot wrap the result.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_cnt <= '0;
    end else if (start_ok) begin
      run_cnt <= '0;
    end else if (state == ST_RUNDOWN && comp_s && run_cnt != CODE_MAX) begin
      run_cnt <= run_cnt + 1'h1;
    end
  end

  // DAC code for the direct modes, moved once per step.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dac_code_o <= '0;
    end else if (start_ok) begin
      // Stair-step and tracking restart from zero; approximation tries the MSB first.
      dac_code_o <= (mode_i == MODE_SAR) ? CODE_MSB : '0;
    end else if (tick) begin
      case (state)
        ST_STAIR: begin
          if (comp_s && dac_code_o != CODE_MAX) begin
            dac_code_o <= dac_code_o + 1'h1;
          end
        end
        ST_TRACK: begin
          if (comp_s && dac_code_o != CODE_MAX) begin
            dac_code_o <= dac_code_o + 1'h1;
          end else if (!comp_s && dac_code_o != '0) begin
            dac_code_o <= dac_code_o - 1'h1;
          end
        end
        ST_SAR: begin
          dac_code_o <= next_sar_code;
        end
        default: begin
          dac_code_o <= dac_code_o;
        end
      endcase
    end
  end

  // Trial bit walks from MSB to LSB, one position per step.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sar_mask <= '0;
    end else if (start_ok) begin
      sar_mask <= CODE_MSB;
    end else if (state == ST_SAR && tick) begin
      sar_mask <= sar_mask >> 1;
    end
  end

  // Result register and done pulse; result changes only together with done.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_o <= '0;
      done_o   <= 1'h0;
    end else begin
      done_o <= 1'h0;
      if (rundown_end) begin
        result_o <= run_cnt;
        done_o   <= 1'h1;
      end else if (stair_end) begin
        // Report the highest code at or below the input, not the one that overshot.
        result_o <= (comp_s || dac_code_o == '0) ? dac_code_o : dac_code_o - 1'h1;
        done_o   <= 1'h1;
      end else if (sar_end) begin
        result_o <= next_sar_code;
        done_o   <= 1'h1;
      end else if (state == ST_TRACK && tick) begin
        result_o <= dac_code_o;
        done_o   <= 1'h1;
      end
    end
  end

  // Busy flag mirrors a non-idle sequencer.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'h0;
    end else if (start_ok) begin
      busy_o <= 1'h1;
    end else if (rundown_end || stair_end || sar_end || track_end) begin
      busy_o <= 1'h0;
    end
  end

  // Helper counters read only by the checks below.
  int unsigned hold_len;
  int unsigned stair_ticks;
  int unsigned sar_ticks;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_len    <= 0;
      stair_ticks <= 0;
      sar_ticks   <= 0;
    end else begin
      hold_len    <= integ_sel_o.to_input ? hold_len + 1 : 0;
      stair_ticks <= start_ok ? 0 : ((state == ST_STAIR && tick) ? stair_ticks + 1 : stair_ticks);
      sar_ticks   <= start_ok ? 0 : ((state == ST_SAR && tick) ? sar_ticks + 1 : sar_ticks);
    end
  end

  // Named steps of the dual-slope and approximation sequences.
  sequence s_rundown_stop;
    state == ST_RUNDOWN && !comp_s;
  endsequence

  sequence s_sar_start;
    start_ok && mode_i == MODE_SAR;
  endsequence

  property p_integ_hold;
    $fell(integ_sel_o.to_input) |-> hold_len == INTEG_CYCLES && integ_sel_o.to_rundown_reference_voltage;
  endproperty
  a_integ_hold: assert property (p_integ_hold) else $error("Integration period length wrong.");

  property p_integ_sel;
    integ_sel_o.to_input |-> state == ST_INTEG && !integ_sel_o.to_rundown_reference_voltage;
  endproperty
  a_integ_sel: assert property (p_integ_sel) else $error("Input selected outside integration.");

  property p_rundown_count;
    state == ST_RUNDOWN && comp_s && run_cnt != CODE_MAX |=> run_cnt == $past(run_cnt) + 1'h1;
  endproperty
  a_rundown_count: assert property (p_rundown_count) else $error("Rundown count missed a clock.");

  property p_rundown_stop;
    s_rundown_stop |=> done_o && result_o == $past(run_cnt) && state == ST_IDLE ##1 !done_o;
  endproperty
  a_rundown_stop: assert property (p_rundown_stop) else $error("Rundown did not stop at threshold.");

  property p_stair_clear;
    start_ok && mode_i == MODE_STAIR |=> dac_code_o == '0 && state == ST_STAIR;
  endproperty
  a_stair_clear: assert property (p_stair_clear) else $error("Stair count not cleared at start.");

  property p_stair_step;
    state == ST_STAIR && tick && comp_s && dac_code_o != CODE_MAX |=> dac_code_o == $past(dac_code_o) + 1'h1;
  endproperty
  a_stair_step: assert property (p_stair_step) else $error("Stair count did not advance.");

  property p_stair_time;
    stair_end |-> stair_ticks < (1 << DATA_W);
  endproperty
  a_stair_time: assert property (p_stair_time) else $error("Stair conversion too long.");

  property p_track_down;
    state == ST_TRACK && tick && !comp_s && dac_code_o != '0 |=> dac_code_o == $past(dac_code_o) - 1'h1;
  endproperty
  a_track_down: assert property (p_track_down) else $error("Tracking did not count down.");

  property p_sar_start;
    s_sar_start |=> dac_code_o == CODE_MSB && sar_mask == CODE_MSB;
  endproperty
  a_sar_start: assert property (p_sar_start) else $error("Approximation did not start at MSB.");

  property p_sar_trial;
    state == ST_SAR && tick |=> ((dac_code_o & $past(sar_mask)) != '0) == $past(comp_s);
  endproperty
  a_sar_trial: assert property (p_sar_trial) else $error("Trial bit settled wrongly.");

  property p_sar_len;
    sar_end |-> sar_ticks == DATA_W - 1;
  endproperty
  a_sar_len: assert property (p_sar_len) else $error("Approximation trial count wrong.");

  property p_done_pulse;
    done_o |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("Done held longer than one cycle.");

  property p_result_stable;
    !done_o |-> $stable(result_o);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("Result changed without done.");

endmodule

// ### core/adc_seq_pkg.sv
// Package with modes, states, carriers and timing constants for the converter sequencer.
package adc_seq_pkg;

  // Default result width in bits.
  localparam int unsigned DATA_W_DEF = 8;

  // System clock period in nanoseconds (10 MHz).
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Length of the fixed integration period in nanoseconds.
  localparam int unsigned FIXED_INTEGRATION_PERIOD_NS = 25600;

  // Cycles of the fixed integration period, rounded up as a least time.
  localparam int unsigned INTEG_CYCLES_DEF =
    (FIXED_INTEGRATION_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // System clocks per conversion step; covers DAC settling plus the two-stage synchroniser.
  localparam int unsigned STEP_DIV_DEF = 3;

  // Conversion mode selected by the host logic.
  typedef enum logic [1:0] {
    MODE_DUAL  = 2'h0,
    MODE_STAIR = 2'h1,
    MODE_TRACK = 2'h2,
    MODE_SAR   = 2'h3
  } conv_mode_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_INTEG   = 3'h1,
    ST_RUNDOWN = 3'h2,
    ST_STAIR   = 3'h3,
    ST_SAR     = 3'h4,
    ST_TRACK   = 3'h5
  } seq_state_t;

  // Integrator input switch controls; both low leaves the integrator open.
  typedef struct packed {
    logic to_input;
    logic to_rundown_reference_voltage;
  } integ_sel_t;

  // Switch setting after reset: integrator disconnected.
  localparam integ_sel_t INTEG_SEL_RESET = 2'h0;

endpackage

// ### test/frontend_model.sv
// Behavioural integrator, comparator and DAC that face the converter sequencer.
`timescale 1ns/1ps
module frontend_model
  import adc_seq_pkg::*;
#(
  parameter int unsigned DATA_W       = 4,
  parameter int unsigned INTEG_CYCLES = 8
) (
  // Clock and reset.
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_n_i,
  // Drive from the sequencer and the bench.
  input  wire adc_seq_pkg::integ_sel_t integ_sel_i,
  input  wire logic [DATA_W-1:0]       dac_code_i,
  input  wire adc_seq_pkg::conv_mode_t mode_i,
  input  wire logic [DATA_W-1:0]       ain_i,
  // Comparator pin.
  output logic                         comp_o
);
  // Integrator charge; signed so that the rundown may cross zero.
  int charge;

  // The input charges by its level each clock and the reference removes INTEG_CYCLES each clock.
  // A reading thus takes about ain_i rundown clocks, which keeps expectations simple.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      charge <= 0;
    end else if (integ_sel_i.to_input) begin
      charge <= charge + int'(ain_i);
    end else if (integ_sel_i.to_rundown_reference_voltage) begin
      charge <= charge - int'(INTEG_CYCLES);
    end else begin
      // An open integrator is discharged so that each conversion starts clean.
      charge <= 0;
    end
  end

  // The comparator settles within the same cycle; no slower front end is modelled.
  always_comb begin
    if (mode_i == MODE_DUAL) begin
      comp_o = (charge > 0);
    end else begin
      comp_o = (dac_code_i <= ain_i);
    end
  end
endmodule

// ### test/tb_adc_count_and_control_sequencer.sv
// Self-checking bench for the converter sequencer with a behavioural front end.
`timescale 1ns/1ps
module tb_adc_count_and_control_sequencer;
  import adc_seq_pkg::*;
  localparam int unsigned N  = 4;  // Narrow word keeps full-scale runs short.
  localparam int unsigned IC = 8;  // Shortened integration period.
  logic       sys_clk_i;           // System clock.
  logic       reset_n_i;           // Active-low reset.
  conv_mode_t mode_i;              // Mode request.
  logic       start_i;             // Start request.
  logic       comp_i;              // Comparator from the model.
  integ_sel_t integ_sel_o;         // Integrator switches.
  logic [N-1:0] dac_code_o;        // DAC word.
  logic [N-1:0] result_o;          // Result word.
  logic       done_o;              // Result valid pulse.
  logic       busy_o;              // Sequencer busy.
  logic [N-1:0] ain;               // Analog input level in DAC codes.
  int         n_mismatch;          // Failed comparisons.
  int         check_count;         // All comparisons.

  adc_count_and_control_sequencer #(.DATA_W(N), .INTEG_CYCLES(IC), .STEP_DIV(3)) i_adc_count_and_control_sequencer (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .mode_i(mode_i), .start_i(start_i), .comp_i(comp_i),
    .integ_sel_o(integ_sel_o), .dac_code_o(dac_code_o), .result_o(result_o), .done_o(done_o), .busy_o(busy_o));

  frontend_model #(.DATA_W(N), .INTEG_CYCLES(IC)) i_frontend_model (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .integ_sel_i(integ_sel_o), .dac_code_i(dac_code_o),
    .mode_i(mode_i), .ain_i(ain), .comp_o(comp_i));

  // Free-running 100 ns clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Inputs change 1 ns after the rising edge, clear of the sampling edge.
  task automatic tick;
    @(posedge sys_clk_i);
    #1;
  endtask

  // Compares with case equality so that an unknown never passes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One conversion; returns edges to done, switch cycle counts and the first DAC word.
  // A refused start may be poked in mid-run; the result must not notice it.
  task automatic conv(input conv_mode_t m, input logic [N-1:0] v, input bit poke,
                      output int n, output int n_in, output int n_ref, output logic [N-1:0] d1);
    logic [N-1:0] prev;
    prev = result_o;
    n_in = 0;
    n_ref = 0;
    ain = v;
    mode_i = m;
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    n = 1;
    d1 = dac_code_o;
    chk(busy_o, 1'b1);
    chk(done_o, 1'b0);
    while (done_o !== 1'b1) begin
      if (n > 60) begin
        n_mismatch++;
        stop_test();
      end
      chk(result_o, prev);
      if (integ_sel_o.to_input) n_in++;
      if (integ_sel_o.to_rundown_reference_voltage) n_ref++;
      start_i = poke && (n == 1);
      tick();
      n++;
    end
  endtask

  // Stair-step runs back to back, including zero and full scale.
  task automatic stair_test;
    int n, ni, nr;
    logic [N-1:0] d1;
    logic [N-1:0] vals [4] = '{4'h0, 4'h7, 4'hF, 4'h3};
    foreach (vals[i]) begin
      conv(MODE_STAIR, vals[i], 1'b0, n, ni, nr, d1);
      chk(d1, 4'h0);
      chk(result_o, vals[i]);
      chk(n <= 3 * (1 << N) + 1, 1'b1);
      chk(busy_o, 1'b0);
    end
  endtask

  // Successive approximation over every code.
  task automatic sar_test;
    int n, ni, nr;
    logic [N-1:0] d1;
    for (int v = 0; v < (1 << N); v++) begin
      conv(MODE_SAR, v[N-1:0], v == 9, n, ni, nr, d1);
      chk(d1, 4'h8);
      chk(result_o, v);
      chk(dac_code_o, v);
      chk(n, 3 * N + 1);
    end
  endtask

  // Dual-slope: fixed integration, counted rundown, switches opened at the end.
  task automatic dual_test;
    int n, ni, nr;
    logic [N-1:0] d1;
    logic [N-1:0] vals [2] = '{4'h3, 4'hA};
    foreach (vals[i]) begin
      conv(MODE_DUAL, vals[i], 1'b0, n, ni, nr, d1);
      chk(ni, IC);
      chk(nr, result_o + 1);
      chk(result_o >= vals[i] && result_o <= vals[i] + 3, 1'b1);
      chk(integ_sel_o, INTEG_SEL_RESET);
    end
  endtask

  // Tracking follows the input up, then down, and stops when the mode changes.
  task automatic track_test;
    int nd;
    logic [N-1:0] vals [2] = '{4'h6, 4'h2};
    mode_i = MODE_TRACK;
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    foreach (vals[i]) begin
      ain = vals[i];
      nd = 0;
      repeat (45) begin
        tick();
        if (done_o === 1'b1) nd++;
      end
      chk(nd > 0, 1'b1);
      chk(dac_code_o + 1 >= ain && dac_code_o <= ain + 1, 1'b1);
    end
    mode_i = MODE_STAIR;
    for (int k = 0; k < 6 && busy_o !== 1'b0; k++) tick();
    chk(busy_o, 1'b0);
  endtask

  // Reset for five cycles, then the scenarios.
  initial begin
    reset_n_i = 1'b0;
    start_i = 1'b0;
    mode_i = MODE_DUAL;
    ain = 4'h0;
    n_mismatch = 0;
    check_count = 0;
    repeat (5) @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b1;
    tick();
    chk(busy_o, 1'b0);
    chk(done_o, 1'b0);
    chk(integ_sel_o, INTEG_SEL_RESET);
    stair_test();
    sar_test();
    dual_test();
    track_test();
    stop_test();
  end
endmodule
